// *** hdl/umf_ack_timer.sv ***
// Acknowledgement timer and retry counter for bandwidth requests
`timescale 1ns/1ns
`default_nettype none
module umf_ack_timer
  import umf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic clear_retry_i,
  input wire logic [15:0] ack_time_i,
  input wire logic [7:0] retry_limit_i,
  output logic expired_o,
  output logic exhausted_o,
  output logic [7:0] retries_o
);
  logic [15:0] count_ff;
  logic run_ff;
  logic [7:0] retry_ff;
  assign expired_o = run_ff && (count_ff >= ack_time_i);
  assign exhausted_o = retry_ff > retry_limit_i;
  assign retries_o = retry_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_i) begin
      run_ff <= 1'b0;
      count_ff <= 16'h0000;
    end else if (start_i) begin
      run_ff <= 1'b1;
      count_ff <= 16'h0000;
    end else if (expired_o) begin
      run_ff <= 1'b0;
    end else if (run_ff) begin
      count_ff <= count_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_retry_i) begin
      retry_ff <= 8'h00;
    end else if (expired_o) begin
      retry_ff <= retry_ff + 8'h01; // [RL8]
    end
  end
endmodule
`default_nettype wire

// *** hdl/umf_frag_engine.sv ***
// Upstream fragmentation engine with Wishbone register access
// Summary of operation
// [RL1] Fragment only when modem and flow enabled
// [RL2] Wrap each piece in header and CRC
// [RL3] Privacy applied per fragment, not frame
// [RL4] Fill partial grant with largest payload
// [RL5] Piggyback when no later grant or pending
// [RL6] Piggyback rides in privacy extended header
// [RL7] Remainder request adds sixteen bytes plus phy
// [RL8] Re-request after ack timeout until limit
// [RL9] Drop unsent part when retries exceeded
// [RL10] First, middle and last flag marking
// [RL11] Sequence number steps by one per fragment
// [RL12] Encrypt from header check through CRC
// [RL13] Never fragment in immediate data regions
// [RL14] Head-end decrypts right after fragment header
// [RL15] Head-end multiple-grant mode keeps state
// [RL16] Head-end sends pending grants until granting
// [RL17] Re-request remainder when maps lack grants
// [RL18] No piggyback when pending accompanies grant
// [RL19] Zero piggyback when grants already queued
// [RL20] Head-end recovers after missed grant
// [RL21] Head-end keeps remainder above minimum fragment
// [RL22] Track remainder and piggyback in piggyback mode
// [RL23] Remainder length goes in piggyback byte
// [RL24] Head-end forwards piggyback, queues fragment
// [RL25] Head-end checks packet header after reassembly
// [RL26] Same behaviour in every grant mode
// [RL27] Head-end reassembles in sequence order
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module umf_frag_engine
  import umf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic frag_valid_o,
  output logic req_valid_o,
  output logic drop_o
);
  // ****************************************
  // Register bank
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [15:0] frame_len_ff;
  logic [15:0] grant_bytes_ff;
  logic [1:0] map_ff;
  logic [7:0] phy_ovh_ff;
  logic [7:0] slot_bytes_ff;
  logic [15:0] ack_time_ff;
  logic [7:0] retry_limit_ff;
  logic [31:0] frag_desc_ff;
  logic [7:0] req_slots_ff;
  logic [15:0] frag_count_ff;
  logic [15:0] drop_count_ff;
  logic frame_go;
  logic grant_go;
  logic wr_en;
  logic rd_en;
  logic ack_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  umf_state_type state_ff;
  logic [15:0] remain_ff;
  logic [7:0] seq_ff;
  logic started_ff;
  logic frag_valid_ff;
  logic req_valid_ff;
  logic drop_ff;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
  assign frame_go = wr_en && (wb_adr_i == REG_FRAME);
  assign grant_go = wr_en && (wb_adr_i == REG_GRANT);
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
      frame_len_ff <= 16'h0000;
      grant_bytes_ff <= 16'h0000;
      map_ff <= 2'b00;
      phy_ovh_ff <= PHY_OVH_RESET;
      slot_bytes_ff <= SLOT_BYTES_RESET;
      ack_time_ff <= ACK_TIME_RESET;
      retry_limit_ff <= RETRY_LIMIT_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        REG_CTRL: ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i);
        REG_FRAME: frame_len_ff <= wb_dat_i[15:0];
        REG_GRANT: begin
          grant_bytes_ff <= wb_dat_i[15:0];
          map_ff <= wb_dat_i[17:16];
        end
        REG_MAPINFO: map_ff <= wb_dat_i[1:0];
        REG_OVH: begin
          phy_ovh_ff <= wb_dat_i[7:0];
          slot_bytes_ff <= wb_dat_i[15:8];
        end
        REG_RETRY: begin
          retry_limit_ff <= wb_dat_i[7:0];
          ack_time_ff <= wb_dat_i[31:16];
        end
        default: begin
        end
      endcase
    end
  end
  // ****************************************
  // Request size and acknowledgement timer
  // ****************************************
  logic [7:0] remain_slots;
  logic [7:0] frame_slots;
  logic tmr_expired;
  logic tmr_exhausted;
  logic [7:0] retries;
  logic tmr_start;
  logic tmr_stop;
  logic tmr_clear;
  umf_req_calc u_remain_calc (
    .bytes_i(remain_ff),
    .add_frag_i(started_ff),
    .phy_ovh_i(phy_ovh_ff),
    .slot_bytes_i(slot_bytes_ff),
    .slots_o(remain_slots)
  );
  umf_ack_timer u_ack_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tmr_start),
    .stop_i(tmr_stop),
    .clear_retry_i(tmr_clear),
    .ack_time_i(ack_time_ff),
    .retry_limit_i(retry_limit_ff),
    .expired_o(tmr_expired),
    .exhausted_o(tmr_exhausted),
    .retries_o(retries)
  );
  assign frame_slots = remain_slots;
  // ****************************************
  // Fragment decision
  // ****************************************
  logic frag_allowed;
  logic [15:0] room;
  logic fits;
  logic queued;
  logic [15:0] pay;
  logic [15:0] nxt_remain;
  assign frag_allowed = ctrl_ff[CTRL_MODEM_EN] && ctrl_ff[CTRL_FLOW_EN]
                        && !ctrl_ff[CTRL_IMM_REGION]; // [RL1] [RL13]
  assign queued = map_ff[MAP_LATER_GRANT] || map_ff[MAP_GRANT_PEND];
  always_comb begin
    // Room left after phy overhead, then fragment overhead
    room = (grant_bytes_ff > {8'h00, phy_ovh_ff}) ? grant_bytes_ff - {8'h00, phy_ovh_ff}
                                                  : 16'h0000;
    fits = started_ff ? (room >= remain_ff + FRAG_OVERHEAD) : (room >= remain_ff);
    if (fits) begin
      pay = remain_ff;
    end else if (room > FRAG_OVERHEAD) begin
      pay = room - FRAG_OVERHEAD; // [RL4]
    end else begin
      pay = 16'h0000;
    end
    nxt_remain = remain_ff - pay;
  end
  assign tmr_clear = frame_go;
  assign tmr_stop = grant_go && (state_ff == UMF_WAIT_GRANT);
  // Timer runs whenever the engine waits for a grant, including after queued fragments
  assign tmr_start = (state_ff == UMF_IDLE && frame_go)
                     || (state_ff == UMF_BACKOFF && !tmr_exhausted)
                     || (state_ff == UMF_DONE)
                     || (state_ff == UMF_BUILD && !fits); // [RL8] [RL17]
  // ****************************************
  // Engine state machine
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= UMF_IDLE;
      remain_ff <= 16'h0000;
      seq_ff <= 8'h00;
      started_ff <= 1'b0;
      frag_valid_ff <= 1'b0;
      req_valid_ff <= 1'b0;
      drop_ff <= 1'b0;
      frag_desc_ff <= 32'h0000_0000;
      req_slots_ff <= 8'h00;
      frag_count_ff <= 16'h0000;
      drop_count_ff <= 16'h0000;
    end else begin
      frag_valid_ff <= 1'b0;
      req_valid_ff <= 1'b0;
      drop_ff <= 1'b0;
      case (state_ff)
        UMF_IDLE: begin
          if (frame_go) begin
            remain_ff <= wb_dat_i[15:0];
            started_ff <= 1'b0;
            seq_ff <= 8'h00;
            state_ff <= UMF_WAIT_GRANT;
          end
        end
        UMF_WAIT_GRANT: begin
          if (grant_go) begin
            state_ff <= UMF_BUILD;
          end else if (tmr_expired) begin
            state_ff <= UMF_BACKOFF; // [RL8] [RL17]
          end
        end
        UMF_BACKOFF: begin
          if (tmr_exhausted) begin
            drop_ff <= 1'b1; // [RL9]
            drop_count_ff <= drop_count_ff + 16'h0001;
            remain_ff <= 16'h0000;
            state_ff <= UMF_IDLE;
          end else begin
            req_slots_ff <= frame_slots; // [RL8] [RL7]
            req_valid_ff <= 1'b1;
            state_ff <= UMF_WAIT_GRANT;
          end
        end
        UMF_BUILD: begin
          if (!started_ff && (fits || !frag_allowed)) begin
            // Whole frame in one burst, no fragment header
            frag_desc_ff <= {remain_ff, 8'h00, 8'h00};
            frag_valid_ff <= fits;
            remain_ff <= fits ? 16'h0000 : remain_ff;
            state_ff <= fits ? UMF_IDLE : UMF_WAIT_GRANT;
          end else if (pay == 16'h0000) begin
            state_ff <= UMF_WAIT_GRANT;
          end else begin
            // Fragment with header and CRC, same path in every grant mode
            frag_desc_ff[FRAG_PAY_LSB +: 16] <= pay; // [RL2] [RL26]
            frag_desc_ff[FRAG_SEQ_LSB +: 8] <= seq_ff; // [RL11]
            frag_desc_ff[FRAG_FIRST] <= !started_ff; // [RL10]
            frag_desc_ff[FRAG_LAST] <= started_ff && fits; // [RL10]
            frag_desc_ff[FRAG_ENCRYPT] <= ctrl_ff[CTRL_PRIV_EN]; // [RL3] [RL12]
            frag_desc_ff[FRAG_PIGGY] <= !queued && !fits; // [RL5] [RL6] [RL22] [RL18] [RL19]
            frag_desc_ff[7:4] <= 4'h0;
            // Remainder request, zero when grants queued or pending
            req_slots_ff <= 8'h00; // [RL18] [RL19]
            seq_ff <= seq_ff + 8'h01; // [RL11]
            started_ff <= !fits;
            remain_ff <= nxt_remain; // [RL22]
            frag_valid_ff <= 1'b1;
            frag_count_ff <= frag_count_ff + 16'h0001;
            state_ff <= fits ? UMF_IDLE : UMF_DONE;
          end
        end
        UMF_DONE: begin
          // Piggyback byte carries remainder plus overheads
          if (frag_desc_ff[FRAG_PIGGY]) begin
            req_slots_ff <= remain_slots; // [RL23] [RL7]
          end
          state_ff <= UMF_WAIT_GRANT;
        end
        default: state_ff <= UMF_IDLE;
      endcase
    end
  end
  assign frag_valid_o = frag_valid_ff;
  assign req_valid_o = req_valid_ff;
  assign drop_o = drop_ff;
  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    case (wb_adr_i)
      REG_CTRL: nxt_rdata = ctrl_ff;
      REG_FRAME: nxt_rdata = {16'h0000, frame_len_ff};
      REG_GRANT: nxt_rdata = {14'h0000, map_ff, grant_bytes_ff};
      REG_MAPINFO: nxt_rdata = {30'h0000_0000, map_ff};
      REG_OVH: nxt_rdata = {16'h0000, slot_bytes_ff, phy_ovh_ff};
      REG_RETRY: nxt_rdata = {ack_time_ff, 8'h00, retry_limit_ff};
      REG_STATUS: nxt_rdata = {retries, 5'h00, state_ff, remain_ff};
      REG_FRAG: nxt_rdata = frag_desc_ff;
      REG_REQ: nxt_rdata = {24'h00_0000, req_slots_ff};
      REG_COUNT: nxt_rdata = {drop_count_ff, frag_count_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  first_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
    frag_valid_ff && frag_desc_ff[FRAG_FIRST] |-> !frag_desc_ff[FRAG_LAST])
    else $error("first fragment has last flag");
  seq_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    $rose(state_ff == UMF_DONE) |-> seq_ff == frag_desc_ff[FRAG_SEQ_LSB +: 8] + 8'h01)
    else $error("sequence did not step");
  no_piggy_queued_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
    state_ff == UMF_BUILD && queued && pay != 16'h0000 && started_ff |=> !frag_desc_ff[FRAG_PIGGY])
    else $error("piggyback with grant queued");
  imm_no_frag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
    state_ff == UMF_BUILD && !started_ff && ctrl_ff[CTRL_IMM_REGION] && !fits |=> !frag_valid_ff)
    else $error("fragment in immediate region");
  drop_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
    drop_ff |-> remain_ff == 16'h0000 && state_ff == UMF_IDLE)
    else $error("drop left remainder");
  retry_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    state_ff == UMF_WAIT_GRANT && tmr_expired && !grant_go |=> ##1 (req_valid_ff || drop_ff))
    else $error("no re-request after timeout");
  encrypt_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    frag_valid_ff && (frag_desc_ff[FRAG_FIRST] || frag_desc_ff[FRAG_LAST])
    |-> frag_desc_ff[FRAG_ENCRYPT] == $past(ctrl_ff[CTRL_PRIV_EN]))
    else $error("privacy flag mismatch");
  piggy_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL23]
    state_ff == UMF_DONE && frag_desc_ff[FRAG_PIGGY] |=> req_slots_ff == $past(remain_slots))
    else $error("piggyback length wrong");
endmodule
`default_nettype wire

// *** hdl/umf_pkg.sv ***
// Package of constants and types for the upstream fragmentation engine
package umf_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME = 8'h04;
  localparam logic [7:0] REG_GRANT = 8'h08;
  localparam logic [7:0] REG_MAPINFO = 8'h0C;
  localparam logic [7:0] REG_OVH = 8'h10;
  localparam logic [7:0] REG_RETRY = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_FRAG = 8'h1C;
  localparam logic [7:0] REG_REQ = 8'h20;
  localparam logic [7:0] REG_COUNT = 8'h24;
  // Control fields
  localparam int CTRL_MODEM_EN = 0;
  localparam int CTRL_FLOW_EN = 1;
  localparam int CTRL_PRIV_EN = 2;
  localparam int CTRL_IMM_REGION = 3;
  localparam int CTRL_NEXT_PKT = 4;
  // Map information fields
  localparam int MAP_LATER_GRANT = 0;
  localparam int MAP_GRANT_PEND = 1;
  // Fragment descriptor fields
  localparam int FRAG_FIRST = 0;
  localparam int FRAG_LAST = 1;
  localparam int FRAG_PIGGY = 2;
  localparam int FRAG_ENCRYPT = 3;
  localparam int FRAG_SEQ_LSB = 8;
  localparam int FRAG_PAY_LSB = 16;
  // Fragment overhead in bytes (header, header check and fragment CRC)
  localparam logic [15:0] FRAG_OVERHEAD = 16'h0010;
  localparam logic [15:0] PAY_MIN = 16'h0001;
  localparam logic [7:0] REQ_MAX = 8'hFF;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] RETRY_LIMIT_RESET = 8'h10;
  localparam logic [15:0] ACK_TIME_RESET = 16'h0400;
  localparam logic [7:0] SLOT_BYTES_RESET = 8'h10;
  localparam logic [7:0] PHY_OVH_RESET = 8'h20;
  // Engine states
  typedef enum logic [2:0] {
    UMF_IDLE,
    UMF_WAIT_GRANT,
    UMF_BUILD,
    UMF_BACKOFF,
    UMF_DONE
  } umf_state_type;
endpackage

// *** hdl/umf_req_calc.sv ***
// Converts a byte count plus overheads into a mini-slot request
`timescale 1ns/1ns
`default_nettype none
module umf_req_calc
  import umf_pkg::*;
(
  input wire logic [15:0] bytes_i,
  input wire logic add_frag_i,
  input wire logic [7:0] phy_ovh_i,
  input wire logic [7:0] slot_bytes_i,
  output logic [7:0] slots_o
);
  logic [17:0] total;
  logic [17:0] slots;
  always_comb begin
    // Remainder plus physical overhead, plus fragment overhead when add_frag_i is set
    total = {2'b00, bytes_i} + {10'h000, phy_ovh_i}; // [RL7]
    if (add_frag_i) begin
      total = total + {2'b00, FRAG_OVERHEAD}; // [RL7]
    end
    if (slot_bytes_i == 8'h00) begin
      slots = total;
    end else begin
      slots = (total + {10'h000, slot_bytes_i} - 18'h00001) / {10'h000, slot_bytes_i};
    end
    slots_o = (slots > {10'h000, REQ_MAX}) ? REQ_MAX : slots[7:0];
  end
endmodule
`default_nettype wire

// *** sim/umf_frag_engine_tb_top.sv ***
// Testbench for the upstream fragmentation engine
`timescale 1ns/1ns
`default_nettype none
module umf_frag_engine_tb_top
  import umf_pkg::*;
;
  // ************************************
  // Signals and instances
  // ************************************
  localparam int SLOT = 16;
  localparam int PHY = 32;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack;
  logic fv;
  logic rv;
  logic dv;
  int failures = 0;
  int n_checks = 0;
  int nfrag = 0;
  int nreq = 0;
  int ndrop = 0;

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (fv === 1'b1) nfrag++;
    if (rv === 1'b1) nreq++;
    if (dv === 1'b1) ndrop++;
  end

  umf_frag_engine DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .frag_valid_o(fv), .req_valid_o(rv), .drop_o(dv));

  umf_headend_model hm ();

  // ************************************
  // Shared tasks
  // ************************************
  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic fail_to(input string nm);
    failures++;
    $display("[ERR] %s expected event seen timeout", nm);
    print_verdict();
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) fail_to("wb_ack_o");
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic wait_cnt(ref int c, input int target, input int lim, input string nm);
    int n;
    n = 0;
    while (c < target && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (c < target) fail_to(nm);
  endtask

  function automatic int slots(input int b);
    return (b + SLOT - 1) / SLOT;
  endfunction

  task automatic frag_after_grant(input logic [31:0] g, input logic [15:0] pay,
                                  input logic [3:0] fl, output logic [31:0] w);
    int n;
    n = nfrag;
    wr(REG_GRANT, g);
    wait_cnt(nfrag, n + 1, 50, "frag_valid_o");
    rd(REG_FRAG, w);
    chk("fragment payload", {16'h0000, pay}, {16'h0000, w[31:16]});
    chk("fragment flags", {28'h0, fl}, {28'h0, w[3:0]});
  endtask

  // ************************************
  // Three-fragment frame
  // ************************************
  task automatic run_frame(input logic priv, input logic [1:0] mm);
    logic [31:0] w;
    logic [31:0] r;
    logic [7:0] sq;
    int n;
    wr(REG_CTRL, {29'h0, priv, 2'b11});
    // Frame sized so every payload remainder stays above a minimum fragment
    wr(REG_FRAME, 32'h0000_0084);
    frag_after_grant(32'd80, 16'd32, {priv, 3'b101}, w);
    sq = w[15:8];
    hm.take(w);
    rd(REG_REQ, r);
    chk("piggyback slots", slots(100 + 16 + PHY), {24'h0, r[7:0]});
    frag_after_grant({14'h0, mm, 16'd80}, 16'd32, {priv, 3'b000}, w);
    chk("middle sequence", {24'h0, sq + 8'h01}, {24'h0, w[15:8]});
    hm.take(w);
    n = nreq;
    wait_cnt(nreq, n + 1, 300, "remainder re-request");
    rd(REG_REQ, r);
    chk("re-request slots", slots(68 + 16 + PHY), {24'h0, r[7:0]});
    frag_after_grant(32'd200, 16'h0044, {priv, 3'b010}, w);
    chk("last sequence", {24'h0, sq + 8'h02}, {24'h0, w[15:8]});
    hm.take(w);
    chk("reassembled length", 32'h0000_0084, hm.last_len);
    chk("reassembly errors", 32'd0, hm.errs);
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [31:0] r;
    logic [31:0] w;
    logic [31:0] ct [2];
    int n;
    int d;
    ct[0] = 32'h0000_000B;
    ct[1] = 32'h0000_0001;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Register reset values and an unmapped place
    rd(REG_CTRL, r);
    chk("ctrl reset", CTRL_RESET, r);
    rd(REG_RETRY, r);
    chk("retry reset", {ACK_TIME_RESET, 8'h00, RETRY_LIMIT_RESET}, r);
    rd(REG_OVH, r);
    chk("overhead reset", {16'h0000, SLOT_BYTES_RESET, PHY_OVH_RESET}, r);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, r);
    chk("unmapped read", 32'h0000_0000, r);
    wr(REG_MAPINFO, 32'h0000_0003);
    rd(REG_MAPINFO, r);
    chk("map info", 32'h0000_0003, r);
    wr(REG_OVH, {16'h0000, 8'(SLOT), 8'(PHY)});
    wr(REG_RETRY, 32'h0040_0002);
    // Retries run out with no grant
    wr(REG_CTRL, 32'h0000_0003);
    n = nreq;
    d = ndrop;
    wr(REG_FRAME, 32'd100);
    wait_cnt(ndrop, d + 1, 1000, "drop_o");
    chk("re-requests before drop", 32'd2, nreq - n);
    rd(REG_REQ, r);
    chk("whole frame request", slots(100 + PHY), {24'h0, r[7:0]});
    run_frame(1'b0, 2'b01);
    run_frame(1'b1, 2'b10);
    // Immediate region and disabled flow never fragment
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, ct[i]);
      wr(REG_FRAME, 32'd100);
      n = nfrag;
      wr(REG_GRANT, 32'd80);
      repeat (10) @(negedge clk_i);
      chk("no fragment on small grant", n, nfrag);
      frag_after_grant(32'd200, 16'd100, 4'h0, w);
    end
    rd(REG_COUNT, r);
    chk("drop and fragment counts", {16'h0001, 16'h0006}, r);
    chk("encrypted fragments", 32'h0000_0003, hm.enc_frags);
    chk("piggyback requests", 32'h0000_0002, hm.piggy_reqs);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** sim/umf_headend_model.sv ***
// Head-end reassembler model fed with fragment descriptors
`timescale 1ns/1ns
`default_nettype none
module umf_headend_model
  import umf_pkg::*;
;
  // ************************************
  // Reassembly state
  // ************************************
  int acc = 0;
  int last_len = 0;
  int errs = 0;
  int piggy_reqs = 0;
  int enc_frags = 0;
  logic in_frame = 1'b0;
  logic [7:0] exp_seq = 8'h00;

  // ************************************
  // Fragment intake
  // ************************************
  task automatic take(input logic [31:0] w);
    if (w[FRAG_PIGGY] === 1'b1) begin
      piggy_reqs++;
    end
    // Encrypted fragments are only counted, decryption is not modelled
    if (w[FRAG_ENCRYPT] === 1'b1) begin
      enc_frags++;
    end
    if (w[FRAG_FIRST] === 1'b1) begin
      if (in_frame) begin
        errs++;
      end
      in_frame = 1'b1;
      acc = 0;
    end else if (!in_frame || w[15:8] !== exp_seq) begin
      errs++;
      in_frame = 1'b0;
    end
    exp_seq = w[15:8] + 8'h01;
    acc += int'(w[31:16]);
    if (w[FRAG_LAST] === 1'b1 && in_frame) begin
      last_len = acc;
      in_frame = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
